// >>> rtl/fsr_pkg.sv
/*
  Package for the fault and warning status bank: register offsets, field
  positions, reset values, channel state codes and the packed carriers.
  Assumes nothing of its surroundings.
*/
package fsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DC_DIAG_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_LINE_OUTPUT_RESULT = 8'h0E;
  localparam logic [7:0] ADDR_CHANNEL_STATE_REPORT = 8'h0F;
  localparam logic [7:0] ADDR_CHANNEL_FAULT_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_FLAGS_ONE = 8'h11;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_FLAGS_TWO = 8'h12;
  localparam logic [7:0] ADDR_WARNING_FLAGS = 8'h13;
  localparam logic [7:0] ADDR_PIN_REPORT_MASKS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SHORT_TO_GROUND = 7;
  localparam int BIT_SHORT_TO_SUPPLY = 6;
  localparam int BIT_OPEN_LOAD = 5;
  localparam int BIT_SHORTED_LOAD = 4;
  localparam int BIT_LINE_LEVEL_LOAD = 3;
  localparam int BIT_STATE_HI = 7;
  localparam int BIT_STATE_LO = 6;
  localparam int BIT_OVERCURRENT = 7;
  localparam int BIT_DC_OFFSET = 3;
  localparam int BIT_INVALID_CLOCK = 4;
  localparam int BIT_STAGE_OV = 3;
  localparam int BIT_BATTERY_OV = 2;
  localparam int BIT_STAGE_UV = 1;
  localparam int BIT_BATTERY_UV = 0;
  localparam int BIT_GLOBAL_TSD = 4;
  localparam int BIT_CHANNEL_TSD = 3;
  localparam int BIT_POWER_ON_RESET = 5;
  localparam int BIT_GLOBAL_TW = 4;
  localparam int BIT_CHANNEL_TW = 3;
  localparam int BIT_SUPPRESS_OC = 7;
  localparam int BIT_SUPPRESS_TSD = 6;
  localparam int BIT_SUPPRESS_UV = 5;
  localparam int BIT_SUPPRESS_OV = 4;
  localparam int BIT_SUPPRESS_DC = 3;
  localparam int BIT_SUPPRESS_CLIP = 1;
  localparam int BIT_SUPPRESS_TW = 0;

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DC_DIAG_RESULT = 8'h00;
  localparam logic [7:0] RST_LINE_OUTPUT_RESULT = 8'h00;
  localparam logic [7:0] RST_CHANNEL_STATE_REPORT = 8'h40;
  localparam logic [7:0] RST_CHANNEL_FAULT_FLAGS = 8'h00;
  localparam logic [7:0] RST_GLOBAL_FAULT_FLAGS_ONE = 8'h00;
  localparam logic [7:0] RST_GLOBAL_FAULT_FLAGS_TWO = 8'h00;
  localparam logic [7:0] RST_WARNING_FLAGS = 8'h20;
  localparam logic [7:0] RST_PIN_REPORT_MASKS = 8'h00;
  localparam logic [7:0] PIN_MASK_WRITABLE = 8'hFB;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Channel state codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSR_STATE_PLAY = 2'b00,
    FSR_STATE_HIGH_Z = 2'b01,
    FSR_STATE_MUTE = 2'b10,
    FSR_STATE_DC_DIAG = 2'b11
  } fsr_chan_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic output_short_to_ground_flag;
    logic output_short_to_supply_flag;
    logic open_load_flag;
    logic shorted_load_flag;
    logic line_level_load_flag;
    fsr_chan_state_t channel_state_field;
    logic overcurrent_flag;
    logic dc_offset_fault_flag;
    logic invalid_clock_flag;
    logic stage_supply_overvoltage_flag;
    logic battery_overvoltage_flag;
    logic stage_supply_undervoltage_flag;
    logic battery_undervoltage_flag;
    logic global_thermal_shutdown_flag;
    logic channel_thermal_shutdown_flag;
    logic global_thermal_warning_flag;
    logic channel_thermal_warning_flag;
    logic clip_flag;
  } fsr_cond_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsr_req_t;

endpackage : fsr_pkg

// >>> rtl/fsr_flag_reg.sv
/*
  One status register: samples its assembled byte every clock.
  Assumes its input comes from logic on the same clock.
*/
`timescale 1ns/10ps

module fsr_flag_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] next_value,
  output logic [WIDTH-1:0] value
);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      value <= RESET_VALUE;
    else
      value <= next_value;
  end

endmodule : fsr_flag_reg

// >>> rtl/fsr_bank.sv
/*
  Fault, warning and diagnostic status bank with fault and warning pin
  routing. Status registers follow the detector inputs, the pin mask
  register is written by the host over a simple byte register port.
  Assumes detector inputs are synchronous to clk_sys and that the host
  issues at most one access per cycle.
*/
// How it works
// - Bit 7 of 0x0C: output short to ground
// - Bit 6 of 0x0C: output short to supply
// - Bit 5 of 0x0C: open load detected
// - 0x0C bit 4 shorted load, low bits zero
// - Bit 3 of 0x0E: line level load
// - Bits 7-6 of 0x0F: channel state, reset 01
// - Bit 7 of 0x10: overcurrent fault, reset 0
// - Bit 3 of 0x10: DC offset fault
// - Bit 4 of 0x11: invalid input clock
// - Bits 3 and 2 of 0x11: overvoltage flags
// - Bits 1 and 0 of 0x11: undervoltage flags
// - Bit 4 of 0x12: global thermal shutdown
// - Bit 3 of 0x12: channel thermal shutdown
// - Bit 5 of 0x13: power-on reset, reset 1
// - Bits 4 and 3 of 0x13: thermal warnings
// - Mask bit 7 keeps overcurrent off fault pin
// - Mask bit 6 keeps thermal shutdown off fault
// - Mask bit 5 keeps undervoltage off fault pin
// - Mask bit 4 keeps overvoltage off fault pin
// - Mask bit 3 keeps DC offset off fault
// - Mask bit 1 keeps clipping off its pin
// - Mask bit 0 keeps thermal warning off warn
`timescale 1ns/10ps

module fsr_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host register port
  input wire fsr_pkg::fsr_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Detector conditions
  input wire fsr_pkg::fsr_cond_t cond,
  input wire logic clip_on_fault_pin,
  input wire logic power_on_reset_clear,
  // Open-drain report pins, enable high pulls the pin low
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic warn_pin_out,
  output logic warn_pin_oe
);

  // ----------------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------------
  logic [7:0] next_dc_diag;
  logic [7:0] next_line_out;
  logic [7:0] next_state_rep;
  logic [7:0] next_chan_fault;
  logic [7:0] next_glob_one;
  logic [7:0] next_glob_two;
  logic [7:0] dc_diag_result;
  logic [7:0] line_output_result;
  logic [7:0] channel_state_report;
  logic [7:0] channel_fault_flags;
  logic [7:0] global_fault_flags_one;
  logic [7:0] global_fault_flags_two;
  logic [7:0] warning_flags;
  logic [7:0] pin_report_masks;
  logic clip_seen;

  always_comb
  begin
    next_dc_diag = 8'h00;
    next_dc_diag[fsr_pkg::BIT_SHORT_TO_GROUND] = cond.output_short_to_ground_flag;
    next_dc_diag[fsr_pkg::BIT_SHORT_TO_SUPPLY] = cond.output_short_to_supply_flag;
    next_dc_diag[fsr_pkg::BIT_OPEN_LOAD] = cond.open_load_flag;
    next_dc_diag[fsr_pkg::BIT_SHORTED_LOAD] = cond.shorted_load_flag;
    next_line_out = 8'h00;
    next_line_out[fsr_pkg::BIT_LINE_LEVEL_LOAD] = cond.line_level_load_flag;
    next_state_rep = 8'h00;
    next_state_rep[fsr_pkg::BIT_STATE_HI:fsr_pkg::BIT_STATE_LO] = cond.channel_state_field;
    next_chan_fault = 8'h00;
    next_chan_fault[fsr_pkg::BIT_OVERCURRENT] = cond.overcurrent_flag;
    next_chan_fault[fsr_pkg::BIT_DC_OFFSET] = cond.dc_offset_fault_flag;
    next_glob_one = 8'h00;
    next_glob_one[fsr_pkg::BIT_INVALID_CLOCK] = cond.invalid_clock_flag;
    next_glob_one[fsr_pkg::BIT_STAGE_OV] = cond.stage_supply_overvoltage_flag;
    next_glob_one[fsr_pkg::BIT_BATTERY_OV] = cond.battery_overvoltage_flag;
    next_glob_one[fsr_pkg::BIT_STAGE_UV] = cond.stage_supply_undervoltage_flag;
    next_glob_one[fsr_pkg::BIT_BATTERY_UV] = cond.battery_undervoltage_flag;
    next_glob_two = 8'h00;
    next_glob_two[fsr_pkg::BIT_GLOBAL_TSD] = cond.global_thermal_shutdown_flag;
    next_glob_two[fsr_pkg::BIT_CHANNEL_TSD] = cond.channel_thermal_shutdown_flag;
  end

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_DC_DIAG_RESULT)) u_dc_diag (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_dc_diag),
    .value(dc_diag_result)
  );

  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_LINE_OUTPUT_RESULT)) u_line_out (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_line_out),
    .value(line_output_result)
  );

  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_CHANNEL_STATE_REPORT)) u_state (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_state_rep),
    .value(channel_state_report)
  );

  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_CHANNEL_FAULT_FLAGS)) u_chan_fault (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_chan_fault),
    .value(channel_fault_flags)
  );

  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_GLOBAL_FAULT_FLAGS_ONE)) u_glob_one (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_glob_one),
    .value(global_fault_flags_one)
  );

  fsr_flag_reg #(.WIDTH(8), .RESET_VALUE(fsr_pkg::RST_GLOBAL_FAULT_FLAGS_TWO)) u_glob_two (
    .clk_sys(clk_sys),
    .rst(rst),
    .next_value(next_glob_two),
    .value(global_fault_flags_two)
  );

  // ----------------------------------------------------------------
  // Warning register
  // ----------------------------------------------------------------
  // The power-on bit is set only by reset; a clear pulse drops it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      warning_flags <= fsr_pkg::RST_WARNING_FLAGS;
    else
    begin
      warning_flags <= 8'h00;
      warning_flags[fsr_pkg::BIT_POWER_ON_RESET] <=
        warning_flags[fsr_pkg::BIT_POWER_ON_RESET] & ~power_on_reset_clear;
      warning_flags[fsr_pkg::BIT_GLOBAL_TW] <= cond.global_thermal_warning_flag;
      warning_flags[fsr_pkg::BIT_CHANNEL_TW] <= cond.channel_thermal_warning_flag;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      clip_seen <= 1'b0;
    else
      clip_seen <= cond.clip_flag;
  end

  // ----------------------------------------------------------------
  // Pin mask register and host access
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pin_report_masks <= fsr_pkg::RST_PIN_REPORT_MASKS;
    else if (reg_req.wr && reg_req.addr == fsr_pkg::ADDR_PIN_REPORT_MASKS)
      pin_report_masks <= reg_req.wdata & fsr_pkg::PIN_MASK_WRITABLE;
  end

  logic [7:0] next_rdata;

  always_comb
  begin
    case (reg_req.addr)
      fsr_pkg::ADDR_DC_DIAG_RESULT: next_rdata = dc_diag_result;
      fsr_pkg::ADDR_LINE_OUTPUT_RESULT: next_rdata = line_output_result;
      fsr_pkg::ADDR_CHANNEL_STATE_REPORT: next_rdata = channel_state_report;
      fsr_pkg::ADDR_CHANNEL_FAULT_FLAGS: next_rdata = channel_fault_flags;
      fsr_pkg::ADDR_GLOBAL_FAULT_FLAGS_ONE: next_rdata = global_fault_flags_one;
      fsr_pkg::ADDR_GLOBAL_FAULT_FLAGS_TWO: next_rdata = global_fault_flags_two;
      fsr_pkg::ADDR_WARNING_FLAGS: next_rdata = warning_flags;
      fsr_pkg::ADDR_PIN_REPORT_MASKS: next_rdata = pin_report_masks;
      default: next_rdata = fsr_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  logic next_fault;
  logic next_warn;
  logic clip_reported;

  always_comb
  begin
    clip_reported = clip_seen & ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_CLIP];
    next_fault = global_fault_flags_one[fsr_pkg::BIT_INVALID_CLOCK];
    next_fault = next_fault | (channel_fault_flags[fsr_pkg::BIT_OVERCURRENT] &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_OC]);
    next_fault = next_fault | ((global_fault_flags_two[fsr_pkg::BIT_GLOBAL_TSD] |
      global_fault_flags_two[fsr_pkg::BIT_CHANNEL_TSD]) &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_TSD]);
    next_fault = next_fault | ((global_fault_flags_one[fsr_pkg::BIT_STAGE_UV] |
      global_fault_flags_one[fsr_pkg::BIT_BATTERY_UV]) &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_UV]);
    next_fault = next_fault | ((global_fault_flags_one[fsr_pkg::BIT_STAGE_OV] |
      global_fault_flags_one[fsr_pkg::BIT_BATTERY_OV]) &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_OV]);
    next_fault = next_fault | (channel_fault_flags[fsr_pkg::BIT_DC_OFFSET] &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_DC]);
    next_fault = next_fault | (clip_reported & clip_on_fault_pin);
    next_warn = (warning_flags[fsr_pkg::BIT_GLOBAL_TW] |
      warning_flags[fsr_pkg::BIT_CHANNEL_TW]) &
      ~pin_report_masks[fsr_pkg::BIT_SUPPRESS_TW];
    next_warn = next_warn | (clip_reported & ~clip_on_fault_pin);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fault_pin_out <= 1'b0;
      fault_pin_oe <= 1'b0;
      warn_pin_out <= 1'b0;
      warn_pin_oe <= 1'b0;
    end
    else
    begin
      fault_pin_out <= 1'b0;
      fault_pin_oe <= next_fault;
      warn_pin_out <= 1'b0;
      warn_pin_oe <= next_warn;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_SHORT_GROUND_FLAG: assert property (
    ##1 dc_diag_result[7] == $past(cond.output_short_to_ground_flag))
    else $error("short to ground flag wrong");
  AST_DC_DIAG_LOW_ZERO: assert property (
    dc_diag_result[3:0] == 4'h0 ##1
    dc_diag_result[4] == $past(cond.shorted_load_flag))
    else $error("dc diag byte wrong");
  AST_STATE_FIELD: assert property (
    ##1 channel_state_report == {$past(cond.channel_state_field), 6'h00})
    else $error("channel state report wrong");
  AST_STATUS_WRITE_IGNORED: assert property (
    reg_req.wr && reg_req.addr == fsr_pkg::ADDR_CHANNEL_FAULT_FLAGS |=>
    channel_fault_flags == {$past(cond.overcurrent_flag), 3'h0,
    $past(cond.dc_offset_fault_flag), 3'h0})
    else $error("status register took a write");
  AST_POR_STICKY: assert property (
    !warning_flags[5] |=> !warning_flags[5])
    else $error("power-on bit set again without reset");
  AST_OC_TO_FAULT: assert property (
    cond.overcurrent_flag ##1 !pin_report_masks[7] |=> fault_pin_oe)
    else $error("unmasked overcurrent missing on fault pin");
  AST_UV_MASKED: assert property (
    pin_report_masks == 8'hFB && !clip_on_fault_pin |=> !fault_pin_oe ||
    $past(global_fault_flags_one[4]))
    else $error("masked fault reached fault pin");
  AST_TW_TO_WARN: assert property (
    cond.global_thermal_warning_flag ##1 !pin_report_masks[0] |=> warn_pin_oe)
    else $error("unmasked warning missing on warn pin");
  AST_TW_MASKED: assert property (
    pin_report_masks[0] && pin_report_masks[1] |=> !warn_pin_oe)
    else $error("masked warning reached warn pin");
  AST_READ_LATENCY: assert property (
    reg_req.rd && reg_req.addr == fsr_pkg::ADDR_PIN_REPORT_MASKS && !reg_req.wr |=>
    reg_rvalid && reg_rdata == $past(pin_report_masks))
    else $error("mask read back wrong");
  AST_SUPPLY_SHORT_FLAG: assert property (
    ##1 dc_diag_result[6] == $past(cond.output_short_to_supply_flag))
    else $error("short to supply flag wrong");
  AST_OPEN_LOAD_FLAG: assert property (
    ##1 dc_diag_result[5] == $past(cond.open_load_flag))
    else $error("open load flag wrong");
  AST_LINE_LOAD_BYTE: assert property (
    ##1 line_output_result == {4'h0, $past(cond.line_level_load_flag), 3'h0})
    else $error("line output byte wrong");
  AST_OC_FLAG: assert property (
    ##1 channel_fault_flags[7] == $past(cond.overcurrent_flag))
    else $error("overcurrent flag wrong");
  AST_DC_OFFSET_FLAG: assert property (
    ##1 channel_fault_flags[3] == $past(cond.dc_offset_fault_flag))
    else $error("dc offset flag wrong");
  AST_CLOCK_FLAG: assert property (
    ##1 global_fault_flags_one[4] == $past(cond.invalid_clock_flag))
    else $error("invalid clock flag wrong");
  AST_OV_FLAGS: assert property (
    ##1 global_fault_flags_one[3:2] == {$past(cond.stage_supply_overvoltage_flag),
    $past(cond.battery_overvoltage_flag)})
    else $error("overvoltage flags wrong");
  AST_UV_FLAGS: assert property (
    ##1 global_fault_flags_one[1:0] == {$past(cond.stage_supply_undervoltage_flag),
    $past(cond.battery_undervoltage_flag)})
    else $error("undervoltage flags wrong");
  AST_GLOBAL_TSD_FLAG: assert property (
    ##1 global_fault_flags_two[4] == $past(cond.global_thermal_shutdown_flag))
    else $error("global shutdown flag wrong");
  AST_CHAN_TSD_FLAG: assert property (
    ##1 global_fault_flags_two[3] == $past(cond.channel_thermal_shutdown_flag))
    else $error("channel shutdown flag wrong");
  AST_TW_FLAGS: assert property (
    ##1 warning_flags[4:3] == {$past(cond.global_thermal_warning_flag),
    $past(cond.channel_thermal_warning_flag)})
    else $error("thermal warning flags wrong");
  AST_TSD_TO_FAULT: assert property (
    cond.global_thermal_shutdown_flag ##1 !pin_report_masks[6] |=> fault_pin_oe)
    else $error("unmasked shutdown missing on fault pin");
  AST_UV_TO_FAULT: assert property (
    cond.battery_undervoltage_flag ##1 !pin_report_masks[5] |=> fault_pin_oe)
    else $error("unmasked undervoltage missing on fault pin");
  AST_OV_TO_FAULT: assert property (
    cond.stage_supply_overvoltage_flag ##1 !pin_report_masks[4] |=> fault_pin_oe)
    else $error("unmasked overvoltage missing on fault pin");
  AST_DC_TO_FAULT: assert property (
    cond.dc_offset_fault_flag ##1 !pin_report_masks[3] |=> fault_pin_oe)
    else $error("unmasked dc offset missing on fault pin");
  AST_CLIP_TO_FAULT: assert property (
    cond.clip_flag ##1 !pin_report_masks[1] && clip_on_fault_pin |=> fault_pin_oe)
    else $error("unmasked clipping missing on fault pin");

  COV_FAULT_PIN: cover property (cond.overcurrent_flag ##2 fault_pin_oe);
  COV_WARN_CLIP: cover property (cond.clip_flag && !clip_on_fault_pin ##2 warn_pin_oe);
  COV_MASK_WRITE: cover property (reg_req.wr && reg_req.addr == fsr_pkg::ADDR_PIN_REPORT_MASKS);
  COV_POR_CLEAR: cover property (warning_flags[5] ##1 !warning_flags[5]);

endmodule : fsr_bank

// >>> bench/fsr_host_model.sv
/*
  Behavioural host for the status bank's byte register port: one write or
  one read at a time, launched just after a clock edge.
  Assumes reg_rvalid and reg_rdata answer one cycle after the read strobe.
*/
`timescale 1ns/10ps

module fsr_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output fsr_pkg::fsr_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle address and data show the inverse of the last value, never a stale copy
  initial reg_req = '{addr: 8'hFF, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
    @(posedge clk_sys);
    reg_req <= '{addr: addr, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req <= '{addr: ~addr, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    #1;
    ok = reg_rvalid;
    data = reg_rdata;
  endtask : read_reg
endmodule : fsr_host_model

// >>> bench/fault_status_report_bank_tb.sv
/*
  Self-checking bench for the status bank: reset values, every condition
  alone with masks open and closed, ignored status writes, random traffic.
  Assumes the host model file is compiled before this one.
*/
`timescale 1ns/10ps
`define CHK(name, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected %s expected %h seen %h", name, exp, got); \
    end \
  end

module fault_status_report_bank_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  fsr_pkg::fsr_cond_t cond;
  logic clip_on_fault_pin = 1'b0;
  logic power_on_reset_clear = 1'b0;
  fsr_pkg::fsr_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid, fault_pin_out, fault_pin_oe, warn_pin_out, warn_pin_oe;
  logic [7:0] mask_model = 8'h00;
  logic por_model = 1'b1;
  logic [31:0] seed = 32'h2BF9;
  int mismatches = 0;
  int total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  fsr_bank uut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cond(cond), .clip_on_fault_pin(clip_on_fault_pin),
    .power_on_reset_clear(power_on_reset_clear), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .warn_pin_out(warn_pin_out), .warn_pin_oe(warn_pin_oe));

  fsr_host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xorshift = s ^ (s << 5);
  endfunction : xorshift

  function automatic logic [7:0] exp_reg(input logic [7:0] a, input fsr_pkg::fsr_cond_t c,
                                         input logic [7:0] m, input logic p);
    case (a)
      fsr_pkg::ADDR_DC_DIAG_RESULT: exp_reg = {c.output_short_to_ground_flag,
        c.output_short_to_supply_flag, c.open_load_flag, c.shorted_load_flag, 4'h0};
      fsr_pkg::ADDR_LINE_OUTPUT_RESULT: exp_reg = {4'h0, c.line_level_load_flag, 3'h0};
      fsr_pkg::ADDR_CHANNEL_STATE_REPORT: exp_reg = {c.channel_state_field, 6'h00};
      fsr_pkg::ADDR_CHANNEL_FAULT_FLAGS: exp_reg = {c.overcurrent_flag, 3'h0,
        c.dc_offset_fault_flag, 3'h0};
      fsr_pkg::ADDR_GLOBAL_FAULT_FLAGS_ONE: exp_reg = {3'h0, c.invalid_clock_flag,
        c.stage_supply_overvoltage_flag, c.battery_overvoltage_flag,
        c.stage_supply_undervoltage_flag, c.battery_undervoltage_flag};
      fsr_pkg::ADDR_GLOBAL_FAULT_FLAGS_TWO: exp_reg = {3'h0, c.global_thermal_shutdown_flag,
        c.channel_thermal_shutdown_flag, 3'h0};
      fsr_pkg::ADDR_WARNING_FLAGS: exp_reg = {2'h0, p, c.global_thermal_warning_flag,
        c.channel_thermal_warning_flag, 3'h0};
      fsr_pkg::ADDR_PIN_REPORT_MASKS: exp_reg = m;
      default: exp_reg = 8'h00;
    endcase
  endfunction : exp_reg

  function automatic logic exp_fault(input fsr_pkg::fsr_cond_t c, input logic [7:0] m,
                                     input logic cfp);
    exp_fault = c.invalid_clock_flag | (c.overcurrent_flag & ~m[7])
      | ((c.global_thermal_shutdown_flag | c.channel_thermal_shutdown_flag) & ~m[6])
      | ((c.stage_supply_undervoltage_flag | c.battery_undervoltage_flag) & ~m[5])
      | ((c.stage_supply_overvoltage_flag | c.battery_overvoltage_flag) & ~m[4])
      | (c.dc_offset_fault_flag & ~m[3]) | (c.clip_flag & cfp & ~m[1]);
  endfunction : exp_fault

  function automatic logic exp_warn(input fsr_pkg::fsr_cond_t c, input logic [7:0] m,
                                    input logic cfp);
    exp_warn = ((c.global_thermal_warning_flag | c.channel_thermal_warning_flag) & ~m[0])
      | (c.clip_flag & ~cfp & ~m[1]);
  endfunction : exp_warn

  // ----------------------------------------------------------------
  // Shared checks and stimulus
  // ----------------------------------------------------------------
  task automatic check_all;
    logic [7:0] d;
    logic [7:0] e;
    logic ok;
    logic ef;
    for (int i = 8'h0B; i <= 8'h15; i++)
    begin
      host.read_reg(i[7:0], d, ok);
      e = exp_reg(i[7:0], cond, mask_model, por_model);
      `CHK("read valid", 1'b1, ok)
      `CHK("status high", e[7:4], d[7:4])
      `CHK("status low", e[3:0], d[3:0])
    end
    ef = exp_fault(cond, mask_model, clip_on_fault_pin);
    `CHK("fault pin", ef, fault_pin_oe)
    `CHK("warn pin", exp_warn(cond, mask_model, clip_on_fault_pin), warn_pin_oe)
    `CHK("pin level", 2'b00, {fault_pin_out, warn_pin_out})
  endtask : check_all

  task automatic apply(input fsr_pkg::fsr_cond_t c, input logic [7:0] m, input logic cfp);
    @(posedge clk_sys);
    cond <= c;
    clip_on_fault_pin <= cfp;
    host.write_reg(fsr_pkg::ADDR_PIN_REPORT_MASKS, m);
    mask_model = m & 8'hFB;
    repeat (2) @(posedge clk_sys);
    #1;
    check_all();
  endtask : apply

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  fsr_pkg::fsr_cond_t idle_cond, c;
  logic [31:0] r1;

  initial
  begin
    idle_cond = '0;
    idle_cond.channel_state_field = fsr_pkg::FSR_STATE_HIGH_Z;
    cond = idle_cond;
    repeat (9) @(posedge clk_sys);
    #1;
    `CHK("reset outputs", 3'b000, {reg_rvalid, fault_pin_oe, warn_pin_oe})
    @(posedge clk_sys);
    rst <= 1'b0;
    check_all();
    @(posedge clk_sys);
    power_on_reset_clear <= 1'b1;
    @(posedge clk_sys);
    power_on_reset_clear <= 1'b0;
    por_model = 1'b0;
    check_all();
    for (int s = 0; s < 4; s++)
    begin
      c = idle_cond;
      c.channel_state_field = fsr_pkg::fsr_chan_state_t'(s[1:0]);
      apply(c, 8'h00, 1'b0);
    end
    for (int i = 0; i < 19; i++)
      for (int j = 0; j < 3; j++)
      begin
        c = fsr_pkg::fsr_cond_t'(19'h1 << i);
        apply(c, (j == 2) ? 8'hFF : 8'h00, j[0]);
      end
    for (int a = 8'h0B; a < 8'h14; a++)
    begin
      seed = xorshift(seed);
      host.write_reg(a[7:0], seed[7:0]);
    end
    check_all();
    repeat (40)
    begin
      seed = xorshift(seed);
      r1 = seed;
      seed = xorshift(seed);
      c = fsr_pkg::fsr_cond_t'(r1[18:0] & seed[18:0]);
      seed = xorshift(seed);
      apply(c, seed[7:0], seed[8]);
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    cond <= idle_cond;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    por_model = 1'b1;
    mask_model = 8'h00;
    check_all();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule : fault_status_report_bank_tb
